// ---- test/mgmt_host_model.sv ----
// Management host model: issues one-cycle register requests on mclk.
// Assumes callers enter its task shortly after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module mgmt_host_model
	import port_fault_pkg::*;
(
	input  wire logic mclk,
	output var reg_req_s reg_req
);
	initial reg_req = '0;
	// Holds the request over exactly one taking edge; writing 0 to bit 7 is how the host asks for recovery.
	task automatic access(input logic rd, input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
		reg_req = '{rd: rd, wr: wr, addr: addr, wdata: wdata};
		@(posedge mclk);
		#2;
	endtask
endmodule
`default_nettype wire

// ---- test/port_fault_status_bank_properties.sv ----
// Checker for the port fault status bank register port and alarm outputs.
// Assumes it is bound to port_fault_status_bank and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module port_fault_status_bank_properties
	import port_fault_pkg::*;
(
	input wire logic       mclk,
	input wire logic       reset,
	input wire reg_req_s   reg_req,
	input wire logic [7:0] reg_rdata_q,
	input wire logic       reg_rvalid_q,
	input wire logic       first_alarm_out_q,
	input wire logic       first_alarm_oe_q,
	input wire logic       second_alarm_out_q,
	input wire logic       second_alarm_oe_q,
	input wire logic       first_port_error_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	read_answered_a: assert property (reg_req.rd |=> reg_rvalid_q)
		else $error("read not answered in one cycle");
	valid_needs_read_a: assert property (reg_rvalid_q |-> $past(reg_req.rd))
		else $error("read valid without a read");
	rdata_holds_a: assert property (!reg_req.rd |=> $stable(reg_rdata_q))
		else $error("read data moved without a read");
	pins_low_only_a: assert property (!first_alarm_out_q && !second_alarm_out_q)
		else $error("alarm pin drives a high level");
	status_mirror_a: assert property (reg_req.rd && reg_req.addr == 8'h02
		|=> reg_rdata_q[7:6] == $past({second_alarm_oe_q, first_alarm_oe_q})) else $error("status alarm bits wrong");
	status_unused_a: assert property (reg_req.rd && reg_req.addr == 8'h02 |=> reg_rdata_q[3:0] == 4'h0)
		else $error("status unused bits set");
	unmapped_zero_a: assert property (reg_req.rd && reg_req.addr > 8'h03 |=> reg_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	error_with_alarm_a: assert property ($rose(first_port_error_q) |-> first_alarm_oe_q)
		else $error("error state without port 1 alarm");
	pwrup_once_a: assert property (reg_req.rd && reg_req.addr == 8'h03 ##1 reg_req.rd && reg_req.addr == 8'h03
		|=> !reg_rdata_q[5]) else $error("power-up flag survived a read");
endmodule
`default_nettype wire

// ---- test/port_fault_status_bank_tb.sv ----
// Self-checking bench for the port fault status bank.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module port_fault_status_bank_tb;
	import port_fault_pkg::*;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	reg_req_s    reg_req;
	logic [7:0]  reg_rdata_q;
	logic        reg_rvalid_q;
	fault_cond_s fault_cond = '0;
	logic        alarm2_req = 1'b0, lim1 = 1'b0, lim2 = 1'b0, pwr1 = 1'b0, pwr2 = 1'b0, sleep = 1'b0;
	logic        dis1 = 1'b0, dis2 = 1'b0, auto_en = 1'b0, tog1 = 1'b0, tog2 = 1'b0;
	logic [7:0]  code1 = 8'h00, code2 = 8'h00, e_v, fm;
	logic        a1o, a1e, a2o, a2e, err, both;
	logic [7:0]  exp_q[$];
	logic [31:0] lfsr = 32'h15B92642;
	int          miscompares = 0, cmp_count = 0, cycles = 0;

	mgmt_host_model i_host (.mclk(mclk), .reg_req(reg_req));
	port_fault_status_bank i_dut (.mclk(mclk), .reset(reset), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
		.reg_rvalid_q(reg_rvalid_q), .fault_cond(fault_cond), .second_port_alarm_req(alarm2_req),
		.first_port_limiting_flag(lim1), .second_port_limiting_flag(lim2), .first_port_power_on(pwr1),
		.second_port_power_on(pwr2), .sleep_request(sleep), .first_port_discharging(dis1),
		.second_port_discharging(dis2), .auto_recovery_en(auto_en), .first_sample_toggle(tog1),
		.second_sample_toggle(tog2), .first_load_current_code(code1), .second_load_current_code(code2),
		.first_alarm_out_q(a1o), .first_alarm_oe_q(a1e), .second_alarm_out_q(a2o), .second_alarm_oe_q(a2e),
		.first_port_error_q(err));

	always #25 mclk = ~mclk;

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic settle;
		repeat (5) @(posedge mclk);
		#2;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.access(1'b1, 1'b0, a, 8'h00);
		i_host.access(1'b0, 1'b0, 8'h00, 8'h00);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.access(1'b0, 1'b1, a, d);
		i_host.access(1'b0, 1'b0, 8'h00, 8'h00);
	endtask

	task automatic pin_chk(input string what, input logic seen, input logic e);
		cmp_count++;
		if (seen !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %b seen %b", what, e, seen);
		end
	endtask

	task automatic pulse_reset;
		reset = 1'b1;
		repeat (4) @(posedge mclk);
		#2;
		reset = 1'b0;
		settle();
	endtask

	// Codes are set a cycle ahead of the toggle so the capture never sees them move.
	task automatic sample(input logic [7:0] c1, input logic [7:0] c2);
		code1 = c1;
		code2 = c2;
		@(posedge mclk);
		#2;
		tog1 = ~tog1;
		tog2 = ~tog2;
		settle();
	endtask

	always @(negedge mclk) begin
		if (reg_rvalid_q === 1'b1) begin
			cmp_count++;
			e_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
			if (reg_rdata_q !== e_v) begin
				miscompares++;
				$display("[FAIL] read data expected %h seen %h", e_v, reg_rdata_q);
			end
		end
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			complete_run();
		end
	end

	initial begin
		repeat (4) @(posedge mclk);
		#2;
		reset = 1'b0;
		settle();
		exp_q.push_back(8'h20);
		exp_q.push_back(8'h00);
		i_host.access(1'b1, 1'b0, 8'h03, 8'h00);
		i_host.access(1'b1, 1'b0, 8'h03, 8'h00);
		i_host.access(1'b0, 1'b0, 8'h00, 8'h00);
		rd(8'h00, 8'h00);
		rd(8'h10, 8'h00);
		wr(8'h02, 8'hFF);
		wr(8'h03, 8'hFF);
		rd(8'h02, 8'h00);
		rd(8'h03, 8'h00);
		pwr1 = 1'b1;
		pwr2 = 1'b1;
		for (int i = 0; i < 3; i++) begin
			lfsr = lfsr_next(lfsr);
			sample((i == 2) ? 8'hFF : lfsr[7:0], lfsr[15:8]);
			rd(8'h00, code1);
			rd(8'h01, code2);
		end
		sleep = 1'b1;
		settle();
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		sleep = 1'b0;
		sample(8'h5A, 8'hA5);
		dis1 = 1'b1;
		settle();
		rd(8'h00, 8'h00);
		rd(8'h01, 8'hA5);
		dis1 = 1'b0;
		pwr2 = 1'b0;
		settle();
		rd(8'h01, 8'h00);
		pwr2 = 1'b1;
		sample(8'h3C, 8'hC3);
		rd(8'h00, 8'h3C);
		rd(8'h01, 8'hC3);
		dis2 = 1'b1;
		settle();
		rd(8'h01, 8'h00);
		dis2 = 1'b0;
		lim1 = 1'b1;
		lim2 = 1'b1;
		settle();
		rd(8'h02, 8'h30);
		lim1 = 1'b0;
		lim2 = 1'b0;
		alarm2_req = 1'b1;
		settle();
		rd(8'h02, 8'h80);
		alarm2_req = 1'b0;
		for (int k = 0; k < 6; k++) begin
			fm = (k == 5) ? 8'h40 : 8'(1 << k);
			both = (k == 2 || k == 3);
			fault_cond = fault_cond_s'(6'(1 << k));
			settle();
			rd(8'h02, {both, 1'b1, 6'h00});
			rd(8'h03, 8'h80 | fm);
			pin_chk("first alarm enable", a1e, 1'b1);
			pin_chk("second alarm enable", a2e, both);
			pin_chk("port 1 error output", err, 1'b1);
			pin_chk("alarm output level", a1o | a2o, 1'b0);
			wr(8'h03, 8'h00);
			settle();
			rd(8'h03, 8'h80 | fm);
			fault_cond = '0;
			settle();
			rd(8'h03, 8'h80 | fm);
			rd(8'h03, 8'h80);
			rd(8'h02, 8'h00);
			pin_chk("first alarm enable", a1e, 1'b0);
			pin_chk("port 1 error output", err, 1'b1);
			if (k < 2)
				wr(8'h03, 8'h00);
			else if (k < 4)
				auto_en = 1'b1;
			else
				pwr1 = 1'b0;
			settle();
			auto_en = 1'b0;
			pwr1 = 1'b1;
			settle();
			rd(8'h03, 8'h00);
			pin_chk("port 1 error output", err, 1'b0);
		end
		pulse_reset();
		rd(8'h03, 8'h20);
		pulse_reset();
		pwr1 = 1'b0;
		settle();
		rd(8'h03, 8'h00);
		settle();
		if (exp_q.size() != 0)
			miscompares++;
		complete_run();
	end
endmodule

bind port_fault_status_bank port_fault_status_bank_properties i_props (.mclk(mclk), .reset(reset),
	.reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
	.first_alarm_out_q(first_alarm_out_q), .first_alarm_oe_q(first_alarm_oe_q),
	.second_alarm_out_q(second_alarm_out_q), .second_alarm_oe_q(second_alarm_oe_q),
	.first_port_error_q(first_port_error_q));
`default_nettype wire

// ---- verilog/current_capture.sv ----
// One port's load current reading register.
// Assumes sample is a one-cycle pulse and code_in is stable when it arrives.
`timescale 1ns/100ps
`default_nettype none
`include "port_fault_consts.svh"

module current_capture #(
	parameter int CODE_W = 8
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic              sample,
	input  wire logic              hold_zero,
	input  wire logic [CODE_W-1:0] code_in,
	output logic      [CODE_W-1:0] code_q
);

	generate
		if (CODE_W != 8) begin : g_bad_width
			$error("current_capture serves only an 8-bit code");
		end
	endgenerate

	// Zeroing outranks a sample so a switched-off port never shows a stale load.
	always_ff @(posedge mclk) begin
		if (reset) begin
			code_q <= `CUR_RESET;
		end else if (hold_zero) begin
			code_q <= `CUR_RESET;
		end else if (sample) begin
			code_q <= code_in;
		end
	end

endmodule

`default_nettype wire

// ---- verilog/pin_sync.sv ----
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level that holds for several mclk periods.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_q
);

	logic [WIDTH-1:0] meta_q;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("pin_sync needs WIDTH of at least one");
		end
	endgenerate

	// The first stage feeds only the second stage.
	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

endmodule

`default_nettype wire

// ---- verilog/port_fault_consts.svh ----
// Constants for the port fault status bank: register offsets, bit positions, reset values.
// Assumes inclusion by bare name from design files; holds definitions only.
`ifndef PORT_FAULT_CONSTS_SVH
`define PORT_FAULT_CONSTS_SVH

// Register offsets on the management register port.
`define ADDR_P1_CURRENT     8'h00
`define ADDR_P2_CURRENT     8'h01
`define ADDR_ALERT_STATUS   8'h02
`define ADDR_P1_FAULT       8'h03

// Port status bit positions.
`define STAT_ALARM2         7
`define STAT_ALARM1         6
`define STAT_LIMIT2         5
`define STAT_LIMIT1         4

// Port 1 fault register bit positions.
`define FLT_ERR             7
`define FLT_DRAIN           6
`define FLT_PWRUP           5
`define FLT_LOW             4
`define FLT_HOT             3
`define FLT_OVV             2
`define FLT_BACK            1
`define FLT_OVC             0

// Fault groups: error-causing flags, and flags that raise both alarm outputs.
`define FLT_ERROR_MASK      8'h5F
`define FLT_BOTH_MASK       8'h0C
`define FLT_POR_VALUE       8'h20

// Current reading: unsigned code, 13.3 mA per step, full scale code 255.
`define CUR_LSB_MICROAMP    13300
`define CUR_RESET           8'h00
`define CUR_FULL_SCALE      8'hFF

// Cycles after reset before edge detectors trust the synchronised pins.
`define SYNC_PRIME_W        3

`define BYTE_ZERO           8'h00

`endif

// ---- verilog/port_fault_pkg.sv ----
// Types shared by the port fault status bank files.
// Assumes nothing of its surroundings.
`default_nettype none
package port_fault_pkg;

	// Live fault conditions from the analog front end, port 1 plus shared supply faults.
	typedef struct packed {
		logic drain_fail;
		logic low_output;
		logic overheat;
		logic overvolt;
		logic backfeed;
		logic overcurrent;
	} fault_cond_s;

	// One register access from the serial management engine.
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// Places live conditions at their fault register bit positions.
	function automatic logic [7:0] cond_to_flags(input fault_cond_s c);
		logic [7:0] f;
		f    = 8'h00;
		f[6] = c.drain_fail;
		f[4] = c.low_output;
		f[3] = c.overheat;
		f[2] = c.overvolt;
		f[1] = c.backfeed;
		f[0] = c.overcurrent;
		return f;
	endfunction

endpackage
`default_nettype wire

// ---- verilog/port_fault_status_bank.sv ----
// Status register bank: current readings, alarm and limiting status, port 1 fault flags.
// Assumes a serial management engine on mclk presents one-cycle register requests,
// and that analog comparators and the current converter drive the asynchronous inputs.
`timescale 1ns/100ps
`default_nettype none
`include "port_fault_consts.svh"

module port_fault_status_bank
	import port_fault_pkg::*;
#(
	parameter int CODE_W = 8
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire reg_req_s          reg_req,
	output logic      [7:0]        reg_rdata_q,
	output logic                   reg_rvalid_q,
	input  wire fault_cond_s       fault_cond,
	input  wire logic              second_port_alarm_req,
	input  wire logic              first_port_limiting_flag,
	input  wire logic              second_port_limiting_flag,
	input  wire logic              first_port_power_on,
	input  wire logic              second_port_power_on,
	input  wire logic              sleep_request,
	input  wire logic              first_port_discharging,
	input  wire logic              second_port_discharging,
	input  wire logic              auto_recovery_en,
	input  wire logic              first_sample_toggle,
	input  wire logic              second_sample_toggle,
	input  wire logic [CODE_W-1:0] first_load_current_code,
	input  wire logic [CODE_W-1:0] second_load_current_code,
	output logic                   first_alarm_out_q,
	output logic                   first_alarm_oe_q,
	output logic                   second_alarm_out_q,
	output logic                   second_alarm_oe_q,
	output logic                   first_port_error_q
);

	// Six fault conditions, eleven single control levels and the two current codes.
	localparam int SYNC_W = $bits(fault_cond_s) + 11 + 2 * CODE_W;

	generate
		if (CODE_W != 8) begin : g_bad_width
			$error("port_fault_status_bank serves only an 8-bit current code");
		end
	endgenerate

	// Synchronised copies of every pin input.
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_sync;
	fault_cond_s       cond_s;
	logic              p2_alarm_s;
	logic [1:0]        limiting_s;
	logic [1:0]        power_s;
	logic              sleep_s;
	logic [1:0]        discharge_s;
	logic              auto_s;
	logic [1:0]        toggle_s;
	logic [CODE_W-1:0] code1_s;
	logic [CODE_W-1:0] code2_s;

	assign pins_raw = {fault_cond, second_port_alarm_req,
		second_port_limiting_flag, first_port_limiting_flag,
		second_port_power_on, first_port_power_on, sleep_request,
		second_port_discharging, first_port_discharging, auto_recovery_en,
		second_sample_toggle, first_sample_toggle,
		second_load_current_code, first_load_current_code};

	pin_sync #(
		.WIDTH    (SYNC_W)
	) u_pin_sync (
		.mclk     (mclk),
		.reset    (reset),
		.async_in (pins_raw),
		.sync_q   (pins_sync)
	);

	assign {cond_s, p2_alarm_s, limiting_s, power_s, sleep_s, discharge_s, auto_s,
		toggle_s, code2_s, code1_s} = pins_sync;

	// Edge detectors wait until the synchroniser and their own history hold real pin
	// levels, so a pin already high at reset release is not taken for a toggle.
	logic [`SYNC_PRIME_W-1:0] primed_q;
	logic                     primed;

	always_ff @(posedge mclk) begin
		if (reset) begin
			primed_q <= '0;
		end else begin
			primed_q <= {primed_q[`SYNC_PRIME_W-2:0], 1'b1};
		end
	end

	assign primed = primed_q[`SYNC_PRIME_W-1];

	// Current readings.
	logic [1:0]        toggle_prev_q;
	logic [1:0]        sample_pulse;
	logic [1:0]        hold_zero;
	logic [CODE_W-1:0] cur1_q;
	logic [CODE_W-1:0] cur2_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			toggle_prev_q <= 2'h0;
		end else begin
			toggle_prev_q <= toggle_s;
		end
	end

	// The code has passed the synchroniser by the time its toggle edge is seen,
	// because the converter holds it still from before the toggle flips.
	assign sample_pulse = (toggle_s ^ toggle_prev_q) & {2{~sleep_s & primed}};
	// Zeroing is a level, so a reading stays at zero for the whole time a port is idle.
	assign hold_zero    = {2{sleep_s}} | ~power_s | discharge_s;

	current_capture #(
		.CODE_W    (CODE_W)
	) u_cur1 (
		.mclk      (mclk),
		.reset     (reset),
		.sample    (sample_pulse[0]),
		.hold_zero (hold_zero[0]),
		.code_in   (code1_s),
		.code_q    (cur1_q)
	);

	current_capture #(
		.CODE_W    (CODE_W)
	) u_cur2 (
		.mclk      (mclk),
		.reset     (reset),
		.sample    (sample_pulse[1]),
		.hold_zero (hold_zero[1]),
		.code_in   (code2_s),
		.code_q    (cur2_q)
	);

	// Register access decode.
	logic rd_fault;
	logic wr_fault;
	logic err_write_zero;

	assign rd_fault       = reg_req.rd && (reg_req.addr == `ADDR_P1_FAULT);
	assign wr_fault       = reg_req.wr && (reg_req.addr == `ADDR_P1_FAULT);
	// Writing 1 to the error flag is ignored; hardware alone sets it.
	assign err_write_zero = wr_fault && !reg_req.wdata[`FLT_ERR];

	// Fault evaluation.
	localparam logic [7:0] POR_FLAGS = `FLT_POR_VALUE;

	logic [7:0] live;
	logic       live_error;
	logic       power1_prev_q;
	logic       power1_toggled;
	logic       err_set;
	logic       err_clear;
	logic       err_may_leave;
	logic       err_q;
	logic       err_falls;
	logic       pwrup_q;
	logic [7:0] latched_q;
	logic [7:0] latch_clear;
	logic [7:0] latch_next;
	logic [7:0] flags_view;

	assign live           = cond_to_flags(cond_s);
	assign live_error     = |(live & `FLT_ERROR_MASK);
	assign power1_toggled = primed && (power_s[0] ^ power1_prev_q);

	always_ff @(posedge mclk) begin
		if (reset) begin
			power1_prev_q <= 1'b0;
		end else begin
			power1_prev_q <= power_s[0];
		end
	end

	// Flags whose condition is gone are dropped together with the error flag,
	// so leaving depends only on live faults and the power-up marker.
	assign err_may_leave = !live_error && !pwrup_q;
	assign err_set       = live_error;
	// Power-off clears the flag even with latched bits left, since the port is then idle.
	assign err_clear     = (err_write_zero && err_may_leave)
		|| (auto_s && !live_error)
		|| !power_s[0];

	// Error state flag; a live fault outranks any clear.
	always_ff @(posedge mclk) begin
		if (reset) begin
			err_q <= 1'b0;
		end else if (err_set) begin
			err_q <= 1'b1;
		end else if (err_clear) begin
			err_q <= 1'b0;
		end
	end

	assign err_falls = err_q && err_clear && !err_set;

	// Latched fault flags, bits 6 and 4..0.
	always_comb begin
		latch_clear = 8'h00;
		if (rd_fault) begin
			latch_clear = `FLT_ERROR_MASK & ~live;
		end
		if (err_falls || (err_write_zero && err_may_leave)) begin
			latch_clear = `FLT_ERROR_MASK;
		end
		// A live condition always re-sets its flag in the same cycle.
		latch_next = ((latched_q & ~latch_clear) | live) & `FLT_ERROR_MASK;
	end

	// The read data are captured at this same edge from the old value.
	always_ff @(posedge mclk) begin
		if (reset) begin
			latched_q <= `BYTE_ZERO;
		end else begin
			latched_q <= latch_next;
		end
	end

	// Power-up marker; sleep does not touch it.
	always_ff @(posedge mclk) begin
		if (reset) begin
			pwrup_q <= POR_FLAGS[`FLT_PWRUP];
		end else if (rd_fault || power1_toggled) begin
			pwrup_q <= 1'b0;
		end
	end

	// Bits 7 and 5 come from their own registers; the rest from the latches.
	always_comb begin
		flags_view             = latched_q;
		flags_view[`FLT_ERR]   = err_q;
		flags_view[`FLT_PWRUP] = pwrup_q;
	end

	// Alarm outputs; open drain, so the output value is always low and the enable drives it.
	logic alarm1_d;
	logic alarm2_d;

	// The error flag is left out so the alarm can change while it holds still.
	assign alarm1_d = |(latch_next & `FLT_ERROR_MASK);
	assign alarm2_d = |(latch_next & `FLT_BOTH_MASK) || p2_alarm_s;

	always_ff @(posedge mclk) begin
		if (reset) begin
			first_alarm_oe_q  <= 1'b0;
			second_alarm_oe_q <= 1'b0;
		end else begin
			first_alarm_oe_q  <= alarm1_d;
			second_alarm_oe_q <= alarm2_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			first_alarm_out_q  <= 1'b0;
			second_alarm_out_q <= 1'b0;
		end else begin
			first_alarm_out_q  <= 1'b0;
			second_alarm_out_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			first_port_error_q <= 1'b0;
		end else begin
			first_port_error_q <= err_q;
		end
	end

	// Port status view.
	logic [7:0] status_view;

	always_comb begin
		status_view                = `BYTE_ZERO;
		status_view[`STAT_ALARM2]  = second_alarm_oe_q;
		status_view[`STAT_ALARM1]  = first_alarm_oe_q;
		status_view[`STAT_LIMIT2]  = limiting_s[1];
		status_view[`STAT_LIMIT1]  = limiting_s[0];
	end

	// Read data mux; unmapped offsets and unused bits read as zero.
	logic [7:0] rdata_d;

	always_comb begin
		case (reg_req.addr)
			`ADDR_P1_CURRENT: begin
				rdata_d = cur1_q;
			end
			`ADDR_P2_CURRENT: begin
				rdata_d = cur2_q;
			end
			`ADDR_ALERT_STATUS: begin
				rdata_d = status_view;
			end
			`ADDR_P1_FAULT: begin
				rdata_d = flags_view;
			end
			default: begin
				rdata_d = `BYTE_ZERO;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			reg_rdata_q <= `BYTE_ZERO;
		end else if (reg_req.rd) begin
			reg_rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_req.rd;
		end
	end

endmodule

`default_nettype wire
